// [pkg/sync_pwr_pkg.sv]
// Constants and types for the sync pulse and power control block
package sync_pwr_pkg;
  localparam int unsigned SYNC_DIV_W = 16;
  localparam int unsigned NUM_DRV    = 8;
  localparam int unsigned NUM_CHAN   = 4;
  localparam int unsigned M_DIV_W    = 3;
  localparam int unsigned PN_W       = 17;
  localparam int unsigned PN_TAP_A   = 16;
  localparam int unsigned PN_TAP_B   = 13;
  localparam logic [16:0] PN_SEED    = 17'h00001;
  localparam logic [2:0]  M_DIV_RST  = 3'h1;
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned PIN_RST_WAKE_US = 2;
  localparam int unsigned POR_WAKE_MS     = 70;
  localparam int unsigned PIN_RST_WAKE_CYC = (PIN_RST_WAKE_US * CLK_HZ) / 1_000_000;
  localparam int unsigned POR_WAKE_CYC     = (POR_WAKE_MS * (CLK_HZ / 1000));
  localparam int unsigned WAKE_CNT_W = 20;
  localparam logic [1:0]  MODE_SINGLE = 2'h0;
  localparam logic [1:0]  MODE_PERIOD = 2'h1;
  localparam logic [1:0]  MODE_PN     = 2'h2;
  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_RUN  = 3'b010,
    SYNC_DONE = 3'b100
  } sync_state_t;
endpackage

// [verilog/sync_pwr_ctrl.sv]
// Sync pulse generator with reset and power-down control
//
// What this block does
// [R1] Sync source is the phase detector reference or the feedback divider clock.
// [R2] A sixteen-bit programmable divider further divides the selected source.
// [R3] Single shot, periodic and pseudorandom modes; output retimed to output clock.
// [R4] Single shot: exactly one pulse after trigger set and update committed.
// [R5] Single shot width is divider value plus one half periods.
// [R6] Single shot trigger clears itself after the pulse, ready for another.
// [R7] Periodic: half-period pulses repeat until trigger cleared and committed.
// [R8] Periodic repetition is divider value plus one half periods, two half periods for a value of zero.
// [R9] Periodic output resampled by output clock; half-period slip allowed.
// [R10] Pseudorandom: PN17 pulse sequence at divider rate until trigger cleared.
// [R11] CMOS sync mode enables the outputs whose enable bits are set; each output has its own enable and invert.
// [R12] Output divider gives 50 percent even, 33.3 for three, 40 for five.
// [R13] Driver control bit zero puts that driver in safe power-down.
// [R14] Channel bit four powers down the channel and its attached drivers.
// [R15] Distribution bias off when power control bit four is set.
// [R16] Power control bit one selects total rather than safe power-down.
// [R17] Soft reset bits two and five reset all but register zero; self-clear.
// [R18] Soft reset holds until one further serial clock cycle arrives.
// [R19] Reset pin restores defaults; outputs toggle again after about 2 us.
// [R20] Power-on reset restores buffer defaults; toggling starts after about 70 ms.
// [R21] Sleep pin low stops PLL and dividers, drivers safe off; resumes with registers.
// [R22] Control port stays operational during sleep and accepts writes.
// [R23] Writes buffered; self-clearing update bit applies all changes at once.
// [R24] PN generator is a 17-bit maximal LFSR with nonzero seed.
// [R25] Divider values above one scale as value plus one half periods.
`timescale 1ns/1ps
module sync_pwr_ctrl
  import sync_pwr_pkg::*;
#(
  parameter int unsigned POR_WAKE    = sync_pwr_pkg::POR_WAKE_CYC,
  parameter int unsigned PIN_WAKE    = sync_pwr_pkg::PIN_RST_WAKE_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              por_pulse,
  input  wire logic                              reset_pin_n,
  input  wire logic                              chip_sleep_pin_n,
  input  wire logic                              sclk_edge,
  input  wire logic                              pd_ref_tick,
  input  wire logic                              fb_div_tick,
  input  wire logic                              out_clk_tick,
  input  wire logic                              distribution_clock_input,
  input  wire logic                              buf_sync_src_fb,
  input  wire logic [sync_pwr_pkg::SYNC_DIV_W-1:0] buf_sync_div,
  input  wire logic [1:0]                        buf_sync_mode,
  input  wire logic                              buf_sync_trig_wr,
  input  wire logic                              buf_sync_trig_val,
  input  wire logic                              buf_sync_cmos,
  input  wire logic [1:0]                        buf_cmos_en,
  input  wire logic [1:0]                        buf_cmos_inv,
  input  wire logic [sync_pwr_pkg::M_DIV_W-1:0]  buf_m_div,
  input  wire logic [sync_pwr_pkg::NUM_DRV-1:0]  buf_drv_pd,
  input  wire logic [sync_pwr_pkg::NUM_CHAN-1:0] buf_chan_pd,
  input  wire logic                              buf_dist_pd,
  input  wire logic                              buf_total_pd,
  input  wire logic                              update_req,
  input  wire logic                              soft_rst_req,
  output logic                                   update_pending,
  output logic                                   soft_rst_active,
  output logic                                   sync_trig_active,
  output logic                                   sync_out,
  output logic [1:0]                             sync_cmos_out,
  output logic [1:0]                             sync_cmos_oe,
  output logic                                   clk_out,
  output logic [sync_pwr_pkg::NUM_DRV-1:0]       drv_safe_pd,
  output logic [sync_pwr_pkg::NUM_DRV-1:0]       drv_total_pd,
  output logic                                   dist_bias_off,
  output logic                                   outputs_running
);
  import sync_pwr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Active register copies
  logic                  src_fb_r;
  logic [SYNC_DIV_W-1:0] div_r;
  logic [1:0]            mode_r;
  logic                  trig_r;
  logic                  cmos_r;
  logic [1:0]            cmos_en_r;
  logic [1:0]            cmos_inv_r;
  logic [M_DIV_W-1:0]    m_div_r;
  logic [NUM_DRV-1:0]    drv_pd_r;
  logic [NUM_CHAN-1:0]   chan_pd_r;
  logic                  dist_pd_r;
  logic                  total_pd_r;
  logic                  trig_pend_r;
  logic                  trig_val_r;
  logic                  pend_r;
  logic                  soft_r;
  logic                  any_rst;
  logic                  sleep;
  logic                  single_done;

  assign sleep   = ~chip_sleep_pin_n;
  assign any_rst = sys_rst | por_pulse | ~reset_pin_n | soft_r;

  // [R17] [R18] soft reset hold
  always_ff @(posedge clk) begin
    if (sys_rst | por_pulse | ~reset_pin_n) begin
      soft_r <= 1'b0;
    end else if (soft_rst_req) begin
      soft_r <= 1'b1;
    end else if (sclk_edge) begin
      soft_r <= 1'b0;
    end
  end

  // [R22] [R23] buffer tracking, writes accepted while asleep
  always_ff @(posedge clk) begin
    if (any_rst) begin
      pend_r      <= 1'b0;
      trig_pend_r <= 1'b0;
      trig_val_r  <= 1'b0;
    end else begin
      if (update_req) begin
        pend_r      <= 1'b0;
        trig_pend_r <= 1'b0;
      end
      if (buf_sync_trig_wr) begin
        pend_r      <= 1'b1;
        trig_pend_r <= 1'b1;
        trig_val_r  <= buf_sync_trig_val;
      end
    end
  end

  // [R23] update applies all buffered settings at once
  always_ff @(posedge clk) begin
    if (any_rst) begin
      src_fb_r   <= 1'b0;
      div_r      <= '0;
      mode_r     <= MODE_SINGLE;
      cmos_r     <= 1'b0;
      cmos_en_r  <= 2'h3;
      cmos_inv_r <= 2'h0;
      m_div_r    <= M_DIV_RST;
      drv_pd_r   <= '0;
      chan_pd_r  <= '0;
      dist_pd_r  <= 1'b0;
      total_pd_r <= 1'b0;
    end else if (update_req) begin
      src_fb_r   <= buf_sync_src_fb;
      div_r      <= buf_sync_div;
      mode_r     <= buf_sync_mode;
      cmos_r     <= buf_sync_cmos;
      cmos_en_r  <= buf_cmos_en;
      cmos_inv_r <= buf_cmos_inv;
      m_div_r    <= buf_m_div;
      drv_pd_r   <= buf_drv_pd;
      chan_pd_r  <= buf_chan_pd;
      dist_pd_r  <= buf_dist_pd;
      total_pd_r <= buf_total_pd;
    end
  end

  // [R4] [R6] [R7] trigger bit; self-clear loses to a committed set
  always_ff @(posedge clk) begin
    if (any_rst) begin
      trig_r <= 1'b0;
    end else if (update_req && trig_pend_r) begin
      trig_r <= trig_val_r;
    end else if (single_done) begin
      trig_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up timer after resets
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic                  running;

  // [R19] [R20] output toggling delay
  always_ff @(posedge clk) begin
    if (sys_rst | por_pulse) begin
      wake_cnt_r <= WAKE_CNT_W'(POR_WAKE);
    end else if (~reset_pin_n) begin
      wake_cnt_r <= WAKE_CNT_W'(PIN_WAKE);
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - 1'b1;
    end
  end
  // [R21] sleep stops dividers
  assign running = (wake_cnt_r == '0) && !sleep && !soft_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sync generator
  sync_state_t           st_r;
  logic [SYNC_DIV_W-1:0] cnt_r;
  logic [PN_W-1:0]       pn_r;
  logic                  half_tick;
  logic                  wrap;
  logic                  raw_r;

  // [R1] source select
  assign half_tick = running && (src_fb_r ? fb_div_tick : pd_ref_tick);
  // [R2] [R8] [R25] divider wraps after value plus one half periods
  assign wrap        = half_tick && (cnt_r == div_r);
  assign single_done = (st_r == SYNC_RUN) && (mode_r == MODE_SINGLE) && wrap;

  always_ff @(posedge clk) begin
    if (any_rst || !trig_r || st_r != SYNC_RUN) begin
      cnt_r <= '0;
    end else if (half_tick) begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
    end
  end

  // [R3] mode sequencing
  always_ff @(posedge clk) begin
    if (any_rst) begin
      st_r <= SYNC_IDLE;
    end else begin
      unique case (st_r)
        SYNC_IDLE: begin
          if (trig_r && half_tick) begin
            st_r <= SYNC_RUN;
          end
        end
        SYNC_RUN: begin
          if (single_done || (!trig_r && !raw_r)) begin
            st_r <= SYNC_DONE;
          end
        end
        SYNC_DONE: begin
          st_r <= SYNC_IDLE;
        end
        default: begin
          st_r <= SYNC_IDLE;
        end
      endcase
    end
  end

  // [R24] [R10] PN17 LFSR advanced per divided period
  always_ff @(posedge clk) begin
    if (any_rst) begin
      pn_r <= PN_SEED;
    end else if (wrap && st_r == SYNC_RUN) begin
      pn_r <= {pn_r[PN_W-2:0], pn_r[PN_TAP_A] ^ pn_r[PN_TAP_B]};
    end
  end

  // [R5] [R7] [R10] raw pulse shape; a periodic or PN pulse in flight finishes after trigger drops, a single shot pulse ends at the next half period
  always_ff @(posedge clk) begin
    if (any_rst || st_r == SYNC_DONE) begin
      raw_r <= 1'b0;
    end else if (half_tick && st_r == SYNC_IDLE) begin
      raw_r <= trig_r && (mode_r == MODE_SINGLE);
    end else if (half_tick) begin
      unique case (mode_r)
        MODE_SINGLE: raw_r <= trig_r && !wrap;
        MODE_PERIOD: raw_r <= trig_r && (cnt_r == '0) && (div_r != '0 ? 1'b1 : !raw_r);
        MODE_PN:     raw_r <= trig_r && (cnt_r == '0) && pn_r[0];
        default:     raw_r <= 1'b0;
      endcase
    end
  end

  // [R3] [R9] retime on output clock
  always_ff @(posedge clk) begin
    if (any_rst) begin
      sync_out <= 1'b0;
    end else if (out_clk_tick) begin
      sync_out <= raw_r && running;
    end
  end

  // [R11] CMOS sync outputs
  always_ff @(posedge clk) begin
    if (any_rst) begin
      sync_cmos_out <= 2'h0;
      sync_cmos_oe  <= 2'h0;
    end else if (out_clk_tick) begin
      sync_cmos_out <= {2{raw_r && running}} ^ cmos_inv_r;
      sync_cmos_oe  <= cmos_r ? cmos_en_r : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output divider
  logic [M_DIV_W-1:0] mcnt_r;
  logic [M_DIV_W-1:0] hi_len;

  function automatic logic [M_DIV_W-1:0] high_count(input logic [M_DIV_W-1:0] m);
    high_count = (m[0] && m != 3'h1) ? (m == 3'h3 ? 3'h1 : 3'h2) : (m >> 1);
  endfunction

  // [R12] duty cycle per ratio
  assign hi_len = high_count(m_div_r);
  always_ff @(posedge clk) begin
    if (any_rst || !running) begin
      mcnt_r  <= '0;
      clk_out <= 1'b0;
    end else if (m_div_r <= 3'h1) begin
      clk_out <= distribution_clock_input;
    end else if (out_clk_tick) begin
      mcnt_r  <= (mcnt_r == m_div_r - 1'b1) ? '0 : mcnt_r + 1'b1;
      clk_out <= ((mcnt_r == m_div_r - 1'b1) ? '0 : mcnt_r + 1'b1) < hi_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down controls
  logic [NUM_DRV-1:0] pd_all;

  // [R13] [R14] [R21] per-driver and per-channel, two drivers to a channel
  always_comb begin
    for (int i = 0; i < NUM_DRV; i++) begin
      pd_all[i] = drv_pd_r[i] | chan_pd_r[i/2] | sleep;
    end
  end

  // [R15] [R16] distribution bias and total power-down
  always_ff @(posedge clk) begin
    if (any_rst) begin
      drv_safe_pd   <= '0;
      drv_total_pd  <= '0;
      dist_bias_off <= 1'b0;
    end else begin
      drv_safe_pd   <= (total_pd_r && !sleep) ? '0 : pd_all;
      drv_total_pd  <= (total_pd_r && !sleep) ? pd_all : '0;
      dist_bias_off <= dist_pd_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      update_pending   <= 1'b0;
      soft_rst_active  <= 1'b0;
      sync_trig_active <= 1'b0;
      outputs_running  <= 1'b0;
    end else begin
      update_pending   <= pend_r;
      soft_rst_active  <= soft_r;
      sync_trig_active <= trig_r;
      outputs_running  <= running;
    end
  end
endmodule

// [bench/sync_pwr_ctrl_checker.sv]
// Assertion checker for the sync pulse and power control block
`timescale 1ns/1ps
module sync_pwr_ctrl_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       reset_pin_n,
  input wire logic       chip_sleep_pin_n,
  input wire logic       sclk_edge,
  input wire logic       out_clk_tick,
  input wire logic       soft_rst_req,
  input wire logic       soft_rst_active,
  input wire logic       sync_out,
  input wire logic       outputs_running,
  input wire logic [7:0] drv_safe_pd,
  input wire logic [7:0] drv_total_pd,
  input wire logic       dist_bias_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sleep_held;
    !chip_sleep_pin_n [*5];
  endsequence
  sequence s_soft_held;
    soft_rst_active [*4];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !sync_out && !outputs_running && drv_safe_pd == 8'h00 && !dist_bias_off)
    else $error("outputs not cleared by reset");
  a_sleep_entry_safe: assert property ($fell(chip_sleep_pin_n) |-> ##[1:5] drv_safe_pd == 8'hff)
    else $error("sleep did not reach safe off");
  a_sleep_held_quiet: assert property (s_sleep_held |-> drv_total_pd == 8'h00 && !sync_out)
    else $error("activity during sleep");
  a_soft_rst_hold: assert property (
    soft_rst_active && !sclk_edge && !$past(sclk_edge) && reset_pin_n |=> soft_rst_active)
    else $error("soft reset left without serial clock");
  a_soft_rst_release: assert property (
    soft_rst_active && sclk_edge && !soft_rst_req |-> ##[1:3] !soft_rst_active)
    else $error("soft reset not released");
  a_soft_rst_quiet: assert property (s_soft_held |-> !sync_out)
    else $error("sync during soft reset");
  a_idle_no_sync: assert property (!outputs_running [*4] |-> !sync_out)
    else $error("sync before outputs run");
  a_pd_mode_exclusive: assert property ((drv_safe_pd & drv_total_pd) == 8'h00)
    else $error("driver in safe and total power-down");
  a_sync_retimed: assert property ($changed(sync_out) && $past(chip_sleep_pin_n) &&
    $past(outputs_running) && !$past(soft_rst_active) && $past(reset_pin_n) |-> $past(out_clk_tick))
    else $error("sync edge not on output clock tick");
  a_pin_rst_stops: assert property ($fell(reset_pin_n) |-> ##[0:3] !outputs_running)
    else $error("pin reset did not stop outputs");
endmodule
bind sync_pwr_ctrl sync_pwr_ctrl_checker u_sync_pwr_ctrl_checker (.clk, .sys_rst, .reset_pin_n,
  .chip_sleep_pin_n, .sclk_edge, .out_clk_tick, .soft_rst_req, .soft_rst_active, .sync_out,
  .outputs_running, .drv_safe_pd, .drv_total_pd, .dist_bias_off);

// [bench/sync_sink.sv]
// Converter model that counts sync pulses and measures their width
`timescale 1ns/1ps
module sync_sink (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clr,
  input  wire logic        sync_in,
  output logic      [15:0] pulse_cnt,
  output logic      [15:0] last_width
);
  logic        prev_r;
  logic [15:0] run_r;
  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      prev_r     <= 1'b0;
      run_r      <= 16'h0;
      pulse_cnt  <= 16'h0;
      last_width <= 16'h0;
    end else begin
      prev_r <= sync_in;
      run_r  <= sync_in ? run_r + 16'h1 : 16'h0;
      // Converter acts on the rising edge
      if (sync_in && !prev_r)
        pulse_cnt <= pulse_cnt + 16'h1;
      if (!sync_in && prev_r)
        last_width <= run_r;
    end
  end
endmodule

// [bench/tb_sync_pwr_ctrl.sv]
// Self-checking testbench for the sync pulse and power control block
`timescale 1ns/1ps
module tb_sync_pwr_ctrl;
  import sync_pwr_pkg::*;
  logic        clk, sys_rst, por_pulse, reset_pin_n, chip_sleep_pin_n, sclk_edge, sink_clr;
  logic        pd_ref_tick, fb_div_tick, out_clk_tick, distribution_clock_input;
  logic        buf_sync_src_fb, buf_sync_trig_wr, buf_sync_trig_val, buf_sync_cmos;
  logic [15:0] buf_sync_div, pulse_cnt, last_width;
  logic [1:0]  buf_sync_mode, buf_cmos_en, buf_cmos_inv, sync_cmos_out, sync_cmos_oe;
  logic [2:0]  buf_m_div;
  logic [7:0]  buf_drv_pd, drv_safe_pd, drv_total_pd;
  logic [3:0]  buf_chan_pd;
  logic        buf_dist_pd, buf_total_pd, update_req, soft_rst_req, update_pending;
  logic        soft_rst_active, sync_trig_active, sync_out, clk_out, dist_bias_off;
  logic        outputs_running;
  int          err_total, total_checks, cyc_n, n;
  logic [15:0] div_tab [3] = '{16'h0, 16'h2, 16'h1};
  logic [15:0] wid_tab [3] = '{16'h4, 16'hc, 16'hc};
  logic [2:0]  m_tab [4]   = '{3'h2, 3'h3, 3'h5, 3'h1};
  logic [15:0] hi_tab [4]  = '{16'h1e, 16'h14, 16'h18, 16'h1e};
  sync_pwr_ctrl #(.POR_WAKE(50), .PIN_WAKE(20)) u_sync_pwr_ctrl (.clk, .sys_rst, .por_pulse,
    .reset_pin_n, .chip_sleep_pin_n, .sclk_edge, .pd_ref_tick, .fb_div_tick, .out_clk_tick,
    .distribution_clock_input, .buf_sync_src_fb, .buf_sync_div, .buf_sync_mode,
    .buf_sync_trig_wr, .buf_sync_trig_val, .buf_sync_cmos, .buf_cmos_en, .buf_cmos_inv,
    .buf_m_div, .buf_drv_pd, .buf_chan_pd, .buf_dist_pd, .buf_total_pd, .update_req,
    .soft_rst_req, .update_pending, .soft_rst_active, .sync_trig_active, .sync_out,
    .sync_cmos_out, .sync_cmos_oe, .clk_out, .drv_safe_pd, .drv_total_pd, .dist_bias_off,
    .outputs_running);
  sync_sink u_sync_sink (.clk, .sys_rst, .clr(sink_clr), .sync_in(sync_out), .pulse_cnt,
    .last_width);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic commit();
    update_req = 1'b1;
    step(1);
    update_req = 1'b0;
    step(1);
  endtask
  task automatic set_trig(input logic v);
    buf_sync_trig_val = v;
    buf_sync_trig_wr = 1'b1;
    step(1);
    buf_sync_trig_wr = 1'b0;
    commit();
  endtask
  task automatic sink_reset();
    sink_clr = 1'b1;
    step(1);
    sink_clr = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Half-period, output and input clock ticks, plus the run ceiling
  always @(posedge clk) begin
    #1;
    cyc_n++;
    pd_ref_tick = (cyc_n % 4 == 0);
    fb_div_tick = (cyc_n % 6 == 0);
    out_clk_tick = cyc_n[0];
    distribution_clock_input = ~distribution_clock_input;
    if (cyc_n == 6000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {por_pulse, sclk_edge, pd_ref_tick, fb_div_tick, out_clk_tick, sink_clr} = '0;
    {distribution_clock_input, buf_sync_src_fb, buf_sync_trig_wr, buf_sync_trig_val} = '0;
    {buf_sync_cmos, buf_cmos_en, buf_cmos_inv, buf_drv_pd, buf_chan_pd} = '0;
    {buf_dist_pd, buf_total_pd, update_req, soft_rst_req, buf_sync_div} = '0;
    {sys_rst, reset_pin_n, chip_sleep_pin_n} = 3'h7;
    buf_sync_mode = MODE_SINGLE;
    buf_m_div = 3'h2;
    step(10);
    sys_rst = 1'b0;
    n = 0;
    while (outputs_running !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk("wake delay", 16'h1, 16'(n >= 45 && n <= 56));
    buf_sync_cmos = 1'b1;
    buf_cmos_en = 2'h3;
    buf_cmos_inv = 2'h2;
    commit();
    step(2);
    chk("cmos enables", 16'h3, {14'h0, sync_cmos_oe});
    chk("cmos idle levels", 16'h2, {14'h0, sync_cmos_out});
    buf_cmos_en = 2'h1;
    commit();
    step(2);
    chk("cmos single enable", 16'h1, {14'h0, sync_cmos_oe});
    for (int i = 0; i < 4; i++) begin
      buf_m_div = m_tab[i];
      commit();
      step(20);
      n = 0;
      for (int k = 0; k < 60; k++) begin
        n += clk_out;
        step(1);
      end
      chk("divider high count", hi_tab[i], 16'(n));
    end
    for (int i = 0; i < 3; i++) begin
      buf_sync_src_fb = (i == 2);
      buf_sync_div = div_tab[i];
      sink_reset();
      set_trig(1'b1);
      step(120);
      chk("single pulse count", 16'h1, pulse_cnt);
      chk("single pulse width", wid_tab[i], last_width);
      chk("trigger after pulse", 16'h0, {15'h0, sync_trig_active});
    end
    buf_sync_src_fb = 1'b0;
    buf_sync_div = 16'h3;
    buf_sync_mode = MODE_PERIOD;
    sink_reset();
    set_trig(1'b1);
    step(160);
    set_trig(1'b0);
    step(20);
    chk("periodic count", 16'h1, 16'(pulse_cnt >= 16'h9 && pulse_cnt <= 16'hc));
    chk("periodic width", 16'h4, last_width);
    sink_reset();
    step(60);
    chk("periodic after stop", 16'h0, pulse_cnt);
    buf_sync_mode = MODE_PN;
    buf_sync_div = 16'h0;
    set_trig(1'b1);
    step(200);
    set_trig(1'b0);
    step(20);
    chk("pn pulses seen", 16'h1, 16'(pulse_cnt > 16'h3));
    sink_reset();
    step(40);
    chk("pn after stop", 16'h0, pulse_cnt);
    buf_sync_trig_val = 1'b0;
    buf_sync_trig_wr = 1'b1;
    step(1);
    buf_sync_trig_wr = 1'b0;
    step(1);
    chk("update pending", 16'h1, {15'h0, update_pending});
    commit();
    chk("update applied", 16'h0, {15'h0, update_pending});
    buf_drv_pd = 8'h01;
    buf_chan_pd = 4'h2;
    step(2);
    chk("pd before update", 16'h0, {8'h0, drv_safe_pd});
    commit();
    step(2);
    chk("safe pd", 16'h0d, {8'h0, drv_safe_pd});
    buf_total_pd = 1'b1;
    buf_dist_pd = 1'b1;
    commit();
    step(2);
    chk("total pd", 16'h0d, {8'h0, drv_total_pd});
    chk("bias off", 16'h1, {15'h0, dist_bias_off});
    chip_sleep_pin_n = 1'b0;
    step(6);
    chk("sleep safe", 16'hff, {8'h0, drv_safe_pd});
    {buf_total_pd, buf_dist_pd, buf_chan_pd, buf_drv_pd} = {6'h0, 8'h80};
    commit();
    chip_sleep_pin_n = 1'b1;
    step(6);
    chk("wake pd", 16'h80, {8'h0, drv_safe_pd});
    chk("wake bias", 16'h0, {15'h0, dist_bias_off});
    reset_pin_n = 1'b0;
    step(2);
    reset_pin_n = 1'b1;
    step(2);
    chk("pin reset pd", 16'h0, {8'h0, drv_safe_pd});
    n = 0;
    while (outputs_running !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    chk("pin wake delay", 16'h1, 16'(n >= 15 && n <= 25));
    commit();
    step(2);
    soft_rst_req = 1'b1;
    step(1);
    soft_rst_req = 1'b0;
    step(5);
    chk("soft reset held", 16'h1, {15'h0, soft_rst_active});
    sclk_edge = 1'b1;
    step(1);
    sclk_edge = 1'b0;
    step(3);
    chk("soft reset done", 16'h0, {15'h0, soft_rst_active});
    chk("soft reset pd", 16'h0, {8'h0, drv_safe_pd});
    end_sim();
  end
endmodule
